//--- rsp_defs.svh
// constants of the ramp stop-phase parameter block
// assumes a register port with 8-bit address and 32-bit data
//
// Operation
// - hold 18-bit final deceleration, reset 10, used from threshold to stop
// - hold 18-bit stop velocity, reset 10, ends decelerating motion
// - after reaching zero velocity wait programmed time before next move
// - wait blocks direct jump from stop velocity to reversed start
// - positioning is ramp mode zero; target write starts a ramp only in that mode
`ifndef RSP_DEFS_SVH
`define RSP_DEFS_SVH
`define RSP_ADDR_DECEL     8'h2a
`define RSP_ADDR_STOP_VELOCITY     8'h2b
`define RSP_ADDR_WAIT      8'h2c
`define RSP_DECEL_RESET    18'h0_000a
`define RSP_STOP_VELOCITY_RESET    18'h0_000a
`define RSP_WAIT_RESET     16'h0000
`define RSP_DECEL_MSB      17
`define RSP_STOP_VELOCITY_MSB      17
`define RSP_WAIT_MSB       15
`define RSP_WAIT_UNIT_CLK  10'h200
`define RSP_MODE_POSITION  2'h0
`endif

//--- rsp_pkg.sv
// types of the ramp stop-phase parameter block
// assumes rsp_defs.svh is on the include path
`include "rsp_defs.svh"
package rsp_pkg;
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } rsp_req_t;
    typedef enum logic [2:0] {
        RSP_IDLE    = 3'b001,
        RSP_WAITING = 3'b010,
        RSP_READY   = 3'b100
    } rsp_state_t;
endpackage : rsp_pkg

//--- rsp_wait_timer.sv
// zero-velocity wait timer: counts units of 512 clocks
// assumes start is a one-cycle pulse on the same clock
`timescale 1ns/1ps
module rsp_wait_timer
    import rsp_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        arst_n_i,
    input  wire logic        start_i,
    input  wire logic [15:0] units_i,
    output logic             busy_o
);
    logic [9:0]  sub_reg;
    logic [9:0]  sub_next;
    logic [15:0] unit_reg;
    logic [15:0] unit_next;
    logic        busy_reg;
    logic        busy_next;

    always_comb begin
        sub_next  = sub_reg;
        unit_next = unit_reg;
        busy_next = busy_reg;
        if (start_i) begin
            unit_next = units_i;
            sub_next  = 10'h000;
            busy_next = (units_i != 16'h0000);
        end else if (busy_reg) begin
            if (sub_reg == `RSP_WAIT_UNIT_CLK - 10'h001) begin
                sub_next  = 10'h000;
                unit_next = unit_reg - 16'h0001;
                busy_next = (unit_reg != 16'h0001);
            end else begin
                sub_next = sub_reg + 10'h001;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sub_reg  <= 10'h000;
            unit_reg <= 16'h0000;
            busy_reg <= 1'b0;
        end else begin
            sub_reg  <= sub_next;
            unit_reg <= unit_next;
            busy_reg <= busy_next;
        end
    end

    assign busy_o = busy_reg;
endmodule : rsp_wait_timer

//--- rsp_stop_phase.sv
// stop-phase parameters and standstill wait of the ramp generator
// assumes register port and ramp signals are on mclk_i
`timescale 1ns/1ps
`include "rsp_defs.svh"
module rsp_stop_phase
    import rsp_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        arst_n_i,
    input  rsp_req_t         req_i,
    output logic [31:0]      rdata_o,
    input  wire logic [1:0]  ramp_mode_select_i,
    input  wire logic        target_position_wr_i,
    input  wire logic [17:0] first_velocity_threshold_i,
    input  wire logic [22:0] velocity_abs_i,
    input  wire logic        standstill_i,
    output logic [17:0]      decel_o,
    output logic [17:0]      stop_velocity_o,
    output logic             move_permit_o,
    output logic             ramp_start_o,
    output logic             wait_active_o
);
    // ************************************************
    // registers
    // ************************************************
    logic [17:0] decel_reg;
    logic [17:0] decel_next;
    logic [17:0] stop_velocity_reg;
    logic [17:0] stop_velocity_next;
    logic [15:0] wait_reg;
    logic [15:0] wait_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;

    always_comb begin
        decel_next = decel_reg;
        stop_velocity_next = stop_velocity_reg;
        wait_next  = wait_reg;
        rdata_next = rdata_reg;
        if (req_i.wr) begin
            case (req_i.addr)
                `RSP_ADDR_DECEL: decel_next = req_i.wdata[17:0];
                `RSP_ADDR_STOP_VELOCITY: stop_velocity_next = req_i.wdata[17:0];
                `RSP_ADDR_WAIT:  wait_next  = req_i.wdata[15:0];
                default:         ;
            endcase
        end
        if (req_i.rd) begin
            case (req_i.addr)
                `RSP_ADDR_DECEL: rdata_next = {14'h0000, decel_reg};
                `RSP_ADDR_STOP_VELOCITY: rdata_next = {14'h0000, stop_velocity_reg};
                `RSP_ADDR_WAIT:  rdata_next = {16'h0000, wait_reg};
                default:         rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            decel_reg <= `RSP_DECEL_RESET;
            stop_velocity_reg <= `RSP_STOP_VELOCITY_RESET;
            wait_reg  <= `RSP_WAIT_RESET;
            rdata_reg <= 32'h0000_0000;
        end else begin
            decel_reg <= decel_next;
            stop_velocity_reg <= stop_velocity_next;
            wait_reg  <= wait_next;
            rdata_reg <= rdata_next;
        end
    end

    // ************************************************
    // standstill wait sequencing
    // ************************************************
    rsp_state_t  st_reg;
    rsp_state_t  st_next;
    logic        timer_start;
    logic        timer_busy;
    logic        pending_reg;
    logic        pending_next;
    logic        positioning;

    assign positioning = (ramp_mode_select_i == `RSP_MODE_POSITION);

    always_comb begin
        st_next     = st_reg;
        timer_start = 1'b0;
        case (st_reg)
            RSP_IDLE: begin
                // leaving standstill means a move is under way
                if (!standstill_i) begin
                    st_next = RSP_READY;
                end
            end
            RSP_READY: begin
                if (standstill_i) begin
                    // a zero wait count must cost no cycle at all
                    if (wait_reg == 16'h0000) begin
                        st_next = RSP_IDLE;
                    end else begin
                        st_next     = RSP_WAITING;
                        timer_start = 1'b1;
                    end
                end
            end
            RSP_WAITING: begin
                if (!timer_busy && !timer_start) begin
                    st_next = RSP_IDLE;
                end
            end
            default: st_next = RSP_IDLE;
        endcase
    end

    // a target written in positioning mode during the wait is held and released afterwards
    always_comb begin
        pending_next = pending_reg;
        if (target_position_wr_i && positioning) begin
            pending_next = 1'b1;
        end else if (pending_reg && move_permit_o) begin
            pending_next = 1'b0;
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_reg      <= RSP_IDLE;
            pending_reg <= 1'b0;
        end else begin
            st_reg      <= st_next;
            pending_reg <= pending_next;
        end
    end

    rsp_wait_timer u_timer (
        .mclk_i   (mclk_i),
        .arst_n_i (arst_n_i),
        .start_i  (timer_start),
        .units_i  (wait_reg),
        .busy_o   (timer_busy)
    );

    // no move or reversal while waiting, so stop speed never flips sign
    // gated by the timer so the wait lasts exactly units times 512 clocks
    assign wait_active_o = (st_reg == RSP_WAITING) && timer_busy;
    assign move_permit_o = !wait_active_o && !timer_start;
    assign ramp_start_o  = pending_reg && move_permit_o;

    // final deceleration applies only at or below the first threshold
    assign decel_o = (velocity_abs_i <= {5'h00, first_velocity_threshold_i})
                     ? decel_reg : 18'h0_0000;
    assign stop_velocity_o = stop_velocity_reg;
    assign rdata_o         = rdata_reg;
endmodule : rsp_stop_phase

//--- rsp_stop_phase_props.sv
// port checker of the stop-phase block
// assumes it is bound into rsp_stop_phase
`timescale 1ns/1ps
module rsp_sp_props
    import rsp_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        arst_n_i,
    input  rsp_req_t         req_i,
    input  wire logic [31:0] rdata_o,
    input  wire logic [1:0]  ramp_mode_select_i,
    input  wire logic        target_position_wr_i,
    input  wire logic [17:0] first_velocity_threshold_i,
    input  wire logic [22:0] velocity_abs_i,
    input  wire logic        standstill_i,
    input  wire logic [17:0] decel_o,
    input  wire logic [17:0] stop_velocity_o,
    input  wire logic        move_permit_o,
    input  wire logic        ramp_start_o,
    input  wire logic        wait_active_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);
    a_decel_gate:
    assert property (velocity_abs_i > {5'h00, first_velocity_threshold_i}
        |-> decel_o == 18'h0_0000) else $error("decel above threshold");
    a_stop_hold:
    assert property (!$past(req_i.wr) |-> $stable(stop_velocity_o))
        else $error("stop velocity moved");
    a_wait_block:
    assert property (wait_active_o |-> !move_permit_o)
        else $error("move permitted in wait");
    a_wait_start:
    assert property (wait_active_o |-> !ramp_start_o)
        else $error("start during wait");
    a_start_pulse:
    assert property (ramp_start_o |=> !ramp_start_o)
        else $error("start not a pulse");
    a_wait_width:
    assert property (req_i.rd && req_i.addr == 8'h2c
        |=> rdata_o[31:16] == 16'h0000) else $error("wait upper bits");
    c_wait: cover property ($rose(wait_active_o));
    c_start: cover property (ramp_start_o);
    c_decel: cover property (decel_o != 18'h0_0000);
endmodule : rsp_sp_props
bind rsp_stop_phase rsp_sp_props u_rsp_sp_props (.*);

//--- testbench.sv
// self-checking bench of rsp_stop_phase
// assumes the design drives outputs from mclk_i rising edges
`timescale 1ns/1ps
module testbench;
    import rsp_pkg::*;
    logic        mclk_i = 0, arst_n_i = 0, tw = 0, ss = 0;
    logic [1:0]  mode = 2'h0;
    logic [17:0] thr = 18'h0_0100;
    logic [22:0] vel = 23'h00_0000;
    rsp_req_t    req = '0;
    logic [31:0] rdata_o, seed = 32'h0000_0016, d;
    logic [17:0] decel_o, stop_o;
    logic        permit, start, wact;
    logic [31:0] mdl [4] = '{32'h0000_000a, 32'h0000_000a, 0, 0};
    int          error_cnt = 0, cmp_count = 0, wcnt = 0, starts = 0, k;
    rsp_stop_phase u_rsp_stop_phase (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
        .req_i(req), .rdata_o(rdata_o), .ramp_mode_select_i(mode),
        .target_position_wr_i(tw), .first_velocity_threshold_i(thr),
        .velocity_abs_i(vel), .standstill_i(ss), .decel_o(decel_o),
        .stop_velocity_o(stop_o), .move_permit_o(permit),
        .ramp_start_o(start), .wait_active_o(wact));
    initial forever #50 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        wcnt += wact;
        starts += start;
    end
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task chk(logic [31:0] got, logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task acc(bit w, int i, logic [31:0] dt);
        @(negedge mclk_i);
        req = '{w, !w, 8'h2a + i[7:0], dt};
        @(negedge mclk_i);
        req = '0;
        if (!w) chk(rdata_o, mdl[i]);
    endtask : acc
    task summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : summarize
    initial begin
        #500000;
        error_cnt++;
        summarize();
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (10) @(negedge mclk_i);
        arst_n_i = 1;
        for (k = 0; k < 4; k++) acc(0, k, 0);
        repeat (8) begin
            k = rnd() % 4;
            d = rnd() | 32'h0000_0001;
            acc(1, k, d);
            if (k < 3) mdl[k] = d & (k == 2 ? 32'h0000_ffff : 32'h0003_ffff);
            acc(0, k, 0);
        end
        chk(stop_o, mdl[1]);
        vel = {5'h00, thr} + 1;
        #1 chk(decel_o, 0);
        vel = {5'h00, thr};
        #1 chk(decel_o, mdl[0]);
        for (k = 0; k < 3; k++) begin
            mode = k == 2 ? 2'h1 : 2'h0;
            acc(1, 2, k == 1);
            ss = 0;
            repeat (2) @(negedge mclk_i);
            wcnt = 0;
            starts = 0;
            ss = 1;
            @(negedge mclk_i);
            tw = 1;
            @(negedge mclk_i);
            tw = 0;
            chk(permit, k != 1);
            repeat (1000) if (wact) @(negedge mclk_i);
            repeat (3) @(negedge mclk_i);
            chk(permit, 1);
            chk(wcnt, k == 1 ? 512 : 0);
            chk(starts, k < 2);
        end
        summarize();
    end
endmodule : testbench
